// >>> hw/pdblm_mapper.sv
// Overview of operation
// - Five bus setups: TFT 24, STN dual 16/8, STN single 8/4, mono or colour.
// - 4-bit single STN drives lanes 3..0 only; lanes 23..4 idle.
// - 8-bit single STN drives lanes 7..0 only; lanes 23..8 idle.
// - 8-bit dual STN: upper panel on lanes 3..0, lower on 7..4.
// - 16-bit dual STN: upper panel on lanes 7..0, lower on 15..8.
// - Dual scan shifts upper and lower line pairs together until frame done.
// - Single scan STN sends one line at a time until frame done.
// - Monochrome STN sends one bit per pixel.
// - Colour STN sends three bits per pixel, line length tripled.
// - STN bits go out consecutively across active lanes on successive shifts.
// - TFT: one pixel per shift, blue 23..16, green 15..8, red 7..0.
// - TFT components stay MSB aligned; narrow panels use top bits.
// - Data valid is high only while lanes carry pixel data.
// - Line sync pulses after each line has been shifted out.
`timescale 1ns/1ns
`include "pdblm_defines.svh"

module pdblm_mapper #(
  parameter int COMP_BITS = 8,
  parameter int FIFO_DEPTH = `PDBLM_FIFO_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PIX_CLK,
  input wire logic ENABLE,
  input wire logic [2:0] MODE,
  input wire logic COLOUR,
  input wire logic [`PDBLM_DIM_W-1:0] LINE_PIXELS,
  input wire logic [`PDBLM_DIM_W-1:0] FRAME_LINES,
  input wire logic [`PDBLM_BUS_W-1:0] PIX_DATA,
  input wire logic PIX_VALID,
  output logic PIX_READY,
  output logic BUSY,
  output logic [`PDBLM_BUS_W-1:0] PANEL_DATA_BUS,
  output logic PANEL_DATA_VALID,
  output logic PANEL_LINE_SYNC,
  output logic PANEL_FRAME_SYNC
);

  // ********************************
  // System side declarations
  // ********************************
  pdblm_pkg::pdblm_sys_state_t sstate_q;
  pdblm_pkg::pdblm_mode_t mode_q;
  logic colour_q;
  logic [`PDBLM_CNT_W-1:0] shifts_q, shifts_d;
  logic [`PDBLM_CNT_W-1:0] shift_cnt_q;
  logic [`PDBLM_DIM_W-1:0] lines_q, line_cnt_q;
  logic [`PDBLM_CNT_W-1:0] line_bits;
  logic [`PDBLM_CNT_W-1:0] rounded;
  logic [`PDBLM_BUS_W-1:0] bus_word;
  logic [`PDBLM_BUS_W-1:0] tft_word;
  logic accept, eol, last_line, sof;
  logic fifo_wr_ready;

  // ********************************
  // Link side declarations
  // ********************************
  pdblm_pkg::pdblm_link_state_t lstate_q;
  logic rst_m_q, rst_link_q;
  logic [`PDBLM_WORD_W-1:0] rd_word;
  logic rd_valid, rd_ready;
  logic [3:0] sync_cnt_q;
  logic [`PDBLM_BUS_W-1:0] bus_q;
  logic valid_q, line_sync_q, frame_sync_q;
  logic take;

  // ********************************
  // Line length in shift clocks
  // ********************************
  // Colour STN tripples the bits of each line
  always_comb
  begin
    line_bits = COLOUR ? `PDBLM_CNT_W'(LINE_PIXELS) * `PDBLM_CNT_W'(3)
                         : `PDBLM_CNT_W'(LINE_PIXELS);
    rounded = '0;
    unique case (pdblm_pkg::pdblm_mode_t'(MODE))
      pdblm_pkg::PDBLM_TFT24:
      begin
        rounded = `PDBLM_CNT_W'(LINE_PIXELS);
      end
      pdblm_pkg::PDBLM_STN4_SINGLE, pdblm_pkg::PDBLM_STN8_DUAL:
      begin
        rounded = (line_bits + `PDBLM_CNT_W'(`PDBLM_LANES_4 - 1)) >> `PDBLM_SHIFT_4;
      end
      pdblm_pkg::PDBLM_STN8_SINGLE, pdblm_pkg::PDBLM_STN16_DUAL:
      begin
        rounded = (line_bits + `PDBLM_CNT_W'(`PDBLM_LANES_8 - 1)) >> `PDBLM_SHIFT_8;
      end
      default:
      begin
        rounded = `PDBLM_CNT_W'(LINE_PIXELS);
      end
    endcase
    // A zero length line would never end
    shifts_d = (rounded == '0) ? `PDBLM_CNT_W'(1) : rounded;
  end

  // Config is sampled only between frames, mid-frame edits are ignored
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      mode_q <= pdblm_pkg::PDBLM_TFT24;
      colour_q <= 1'b0;
      shifts_q <= `PDBLM_CNT_W'(1);
      lines_q <= '0;
    end
    else if (sstate_q == pdblm_pkg::PDBLM_S_IDLE && ENABLE)
    begin
      mode_q <= pdblm_pkg::pdblm_mode_t'(MODE);
      colour_q <= COLOUR;
      shifts_q <= shifts_d;
      lines_q <= (FRAME_LINES == '0) ? `PDBLM_DIM_W'(1) : FRAME_LINES;
    end
  end

  // ********************************
  // Lane mapping
  // ********************************
  genvar c;
  generate
    for (c = 0; c < `PDBLM_NUM_COMP; c++)
    begin : g_comp
      // Input component sits in the low bits, panel wants the top bits
      assign tft_word[c*`PDBLM_COMP_W +: `PDBLM_COMP_W] =
        `PDBLM_COMP_W'(PIX_DATA[c*`PDBLM_COMP_W +: COMP_BITS]) << (`PDBLM_COMP_W - COMP_BITS);
    end
  endgenerate

  always_comb
  begin
    bus_word = '0;
    unique case (mode_q)
      pdblm_pkg::PDBLM_TFT24:
      begin
        bus_word = tft_word;
      end
      pdblm_pkg::PDBLM_STN16_DUAL:
      begin
        bus_word[7:0] = PIX_DATA[7:0];
        bus_word[15:8] = PIX_DATA[`PDBLM_LOWER_LSB +: 8];
      end
      pdblm_pkg::PDBLM_STN8_DUAL:
      begin
        bus_word[3:0] = PIX_DATA[3:0];
        bus_word[7:4] = PIX_DATA[`PDBLM_LOWER_LSB +: 4];
      end
      pdblm_pkg::PDBLM_STN8_SINGLE:
      begin
        bus_word[7:0] = PIX_DATA[7:0];
      end
      pdblm_pkg::PDBLM_STN4_SINGLE:
      begin
        bus_word[3:0] = PIX_DATA[3:0];
      end
      default:
      begin
        bus_word = '0;
      end
    endcase
  end

  // ********************************
  // Line and frame sequencing
  // ********************************
  assign accept = PIX_VALID && PIX_READY;
  assign PIX_READY = (sstate_q == pdblm_pkg::PDBLM_S_RUN) && fifo_wr_ready;
  assign BUSY = (sstate_q == pdblm_pkg::PDBLM_S_RUN);
  assign eol = (shift_cnt_q == shifts_q - `PDBLM_CNT_W'(1));
  assign last_line = (line_cnt_q == lines_q - `PDBLM_DIM_W'(1));
  assign sof = (shift_cnt_q == '0) && (line_cnt_q == '0);

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      sstate_q <= pdblm_pkg::PDBLM_S_IDLE;
    end
    else
    begin
      unique case (sstate_q)
        pdblm_pkg::PDBLM_S_IDLE:
        begin
          if (ENABLE)
          begin
            sstate_q <= pdblm_pkg::PDBLM_S_RUN;
          end
        end
        pdblm_pkg::PDBLM_S_RUN:
        begin
          if (accept && eol && last_line)
          begin
            sstate_q <= pdblm_pkg::PDBLM_S_IDLE;
          end
        end
        default:
        begin
          sstate_q <= pdblm_pkg::PDBLM_S_IDLE;
        end
      endcase
    end
  end

  // In dual scan one count covers an upper and lower line pair
  always_ff @(posedge CLK_SYS)
  begin
    if (RST || sstate_q == pdblm_pkg::PDBLM_S_IDLE)
    begin
      shift_cnt_q <= '0;
      line_cnt_q <= '0;
    end
    else if (accept)
    begin
      if (eol)
      begin
        shift_cnt_q <= '0;
        line_cnt_q <= line_cnt_q + `PDBLM_DIM_W'(1);
      end
      else
      begin
        shift_cnt_q <= shift_cnt_q + `PDBLM_CNT_W'(1);
      end
    end
  end

  // ********************************
  // Clock crossing buffer
  // ********************************
  pdblm_fifo #(
    .WIDTH(`PDBLM_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clk(CLK_SYS),
    .wr_rst(RST),
    .wr_data({sof, eol, bus_word}),
    .wr_valid(accept),
    .wr_ready(fifo_wr_ready),
    .rd_clk(PIX_CLK),
    .rd_rst(rst_link_q),
    .rd_data(rd_word),
    .rd_valid(rd_valid),
    .rd_ready(rd_ready)
  );

  // ********************************
  // Link domain reset
  // ********************************
  always_ff @(posedge PIX_CLK)
  begin
    rst_m_q <= RST;
    rst_link_q <= rst_m_q;
  end

  // ********************************
  // Link sequencing
  // ********************************
  // No words are taken during line sync, the buffer absorbs the gap
  assign rd_ready = (lstate_q == pdblm_pkg::PDBLM_L_DATA);
  assign take = rd_ready && rd_valid;

  always_ff @(posedge PIX_CLK)
  begin
    if (rst_link_q)
    begin
      lstate_q <= pdblm_pkg::PDBLM_L_IDLE;
      sync_cnt_q <= '0;
    end
    else
    begin
      unique case (lstate_q)
        pdblm_pkg::PDBLM_L_IDLE:
        begin
          lstate_q <= pdblm_pkg::PDBLM_L_DATA;
        end
        pdblm_pkg::PDBLM_L_DATA:
        begin
          if (take && rd_word[`PDBLM_EOL_BIT])
          begin
            lstate_q <= pdblm_pkg::PDBLM_L_SYNC;
            sync_cnt_q <= `PDBLM_LSYNC_CYCLES - 4'h1;
          end
        end
        pdblm_pkg::PDBLM_L_SYNC:
        begin
          if (sync_cnt_q == '0)
          begin
            lstate_q <= pdblm_pkg::PDBLM_L_DATA;
          end
          else
          begin
            sync_cnt_q <= sync_cnt_q - 4'h1;
          end
        end
        default:
        begin
          lstate_q <= pdblm_pkg::PDBLM_L_IDLE;
        end
      endcase
    end
  end

  // Lanes drop to zero whenever no pixel is shown
  always_ff @(posedge PIX_CLK)
  begin
    if (rst_link_q)
    begin
      bus_q <= '0;
      valid_q <= 1'b0;
    end
    else if (take)
    begin
      bus_q <= rd_word[`PDBLM_BUS_W-1:0];
      valid_q <= 1'b1;
    end
    else
    begin
      bus_q <= '0;
      valid_q <= 1'b0;
    end
  end

  // Delayed a cycle so the pulse follows the last shifted word
  always_ff @(posedge PIX_CLK)
  begin
    if (rst_link_q)
    begin
      line_sync_q <= 1'b0;
    end
    else
    begin
      line_sync_q <= (lstate_q == pdblm_pkg::PDBLM_L_SYNC);
    end
  end

  // Frame sync covers the first line of the frame
  always_ff @(posedge PIX_CLK)
  begin
    if (rst_link_q)
    begin
      frame_sync_q <= 1'b0;
    end
    else if (take && rd_word[`PDBLM_SOF_BIT])
    begin
      frame_sync_q <= 1'b1;
    end
    else if (lstate_q == pdblm_pkg::PDBLM_L_SYNC && sync_cnt_q == '0)
    begin
      frame_sync_q <= 1'b0;
    end
  end

  assign PANEL_DATA_BUS = bus_q;
  assign PANEL_DATA_VALID = valid_q;
  assign PANEL_LINE_SYNC = line_sync_q;
  assign PANEL_FRAME_SYNC = frame_sync_q;

endmodule : pdblm_mapper

// >>> shared/pdblm_defines.svh
`ifndef PDBLM_DEFINES_SVH
`define PDBLM_DEFINES_SVH

// ********************************
// Bus geometry
// ********************************
`define PDBLM_BUS_W 24
`define PDBLM_COMP_W 8
`define PDBLM_NUM_COMP 3
`define PDBLM_WORD_W 26
`define PDBLM_SOF_BIT 25
`define PDBLM_EOL_BIT 24

// ********************************
// Lane splits per configuration
// ********************************
`define PDBLM_LANES_4 4
`define PDBLM_LANES_8 8
`define PDBLM_SHIFT_4 2
`define PDBLM_SHIFT_8 3
`define PDBLM_LOWER_LSB 8

// ********************************
// Timing and sizing
// ********************************
`define PDBLM_FIFO_DEPTH 8
`define PDBLM_LSYNC_CYCLES 4'h2
`define PDBLM_CNT_W 13
`define PDBLM_DIM_W 11

`endif

// >>> shared/pdblm_pkg.sv
package pdblm_pkg;

  typedef enum logic [2:0]
  {
    PDBLM_TFT24 = 3'h0,
    PDBLM_STN16_DUAL = 3'h1,
    PDBLM_STN8_DUAL = 3'h2,
    PDBLM_STN8_SINGLE = 3'h3,
    PDBLM_STN4_SINGLE = 3'h4
  } pdblm_mode_t;

  typedef enum logic [1:0]
  {
    PDBLM_S_IDLE = 2'h1,
    PDBLM_S_RUN = 2'h2
  } pdblm_sys_state_t;

  typedef enum logic [2:0]
  {
    PDBLM_L_IDLE = 3'h1,
    PDBLM_L_DATA = 3'h2,
    PDBLM_L_SYNC = 3'h4
  } pdblm_link_state_t;

endpackage : pdblm_pkg

// >>> hw/pdblm_fifo.sv
`timescale 1ns/1ns

module pdblm_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic rd_clk,
  input wire logic rd_rst,
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
  logic [AW:0] rgray_m_q, rgray_s_q, wgray_m_q, wgray_s_q;
  logic [AW:0] wbin_d, rbin_d;
  logic empty, full, push, fetch;

  // ********************************
  // Write side
  // ********************************
  assign full = (wgray_q == {~rgray_s_q[AW:AW-1], rgray_s_q[AW-2:0]});
  assign wr_ready = !full;
  assign push = wr_valid && !full;
  assign wbin_d = wbin_q + (AW+1)'(1);

  always_ff @(posedge wr_clk)
  begin
    if (push)
    begin
      mem[wbin_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk)
  begin
    if (wr_rst)
    begin
      wbin_q <= '0;
      wgray_q <= '0;
    end
    else if (push)
    begin
      wbin_q <= wbin_d;
      wgray_q <= wbin_d ^ (wbin_d >> 1);
    end
  end

  // Gray pointers cross, one bit changes per step
  always_ff @(posedge wr_clk)
  begin
    rgray_m_q <= rgray_q;
    rgray_s_q <= rgray_m_q;
  end

  // ********************************
  // Read side, registered output stage
  // ********************************
  assign empty = (rgray_q == wgray_s_q);
  assign fetch = !empty && (!rd_valid || rd_ready);
  assign rbin_d = rbin_q + (AW+1)'(1);

  always_ff @(posedge rd_clk)
  begin
    wgray_m_q <= wgray_q;
    wgray_s_q <= wgray_m_q;
  end

  always_ff @(posedge rd_clk)
  begin
    if (rd_rst)
    begin
      rbin_q <= '0;
      rgray_q <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      if (fetch)
      begin
        rd_data <= mem[rbin_q[AW-1:0]];
        rbin_q <= rbin_d;
        rgray_q <= rbin_d ^ (rbin_d >> 1);
        rd_valid <= 1'b1;
      end
      else if (rd_ready)
      begin
        rd_valid <= 1'b0;
      end
    end
  end

endmodule : pdblm_fifo

// >>> sim/pdblm_mapper_sva.sv
`timescale 1ns/1ns

module pdblm_mapper_sva (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PIX_CLK,
  input wire logic [2:0] MODE,
  input wire logic BUSY,
  input wire logic PIX_READY,
  input wire logic [23:0] PANEL_DATA_BUS,
  input wire logic PANEL_DATA_VALID,
  input wire logic PANEL_LINE_SYNC,
  input wire logic PANEL_FRAME_SYNC
);
  // ********************************
  // Panel side, plus one system side ready check
  // ********************************
  sequence sync_tail;
    PANEL_LINE_SYNC ##1 !PANEL_LINE_SYNC;
  endsequence

  chk_sync_width: assert property (@(posedge PIX_CLK) disable iff (RST)
    $rose(PANEL_LINE_SYNC) |=> sync_tail) else $error("line sync width wrong");
  chk_sync_after_data: assert property (@(posedge PIX_CLK) disable iff (RST)
    $rose(PANEL_LINE_SYNC) |-> $past(PANEL_DATA_VALID)) else $error("sync without line");
  chk_sync_no_data: assert property (@(posedge PIX_CLK) disable iff (RST)
    PANEL_LINE_SYNC |-> !PANEL_DATA_VALID) else $error("data during line sync");
  chk_idle_bus_low: assert property (@(posedge PIX_CLK) disable iff (RST)
    !PANEL_DATA_VALID |-> PANEL_DATA_BUS == 24'h0) else $error("bus active without valid");
  chk_lanes_stn4: assert property (@(posedge PIX_CLK) disable iff (RST)
    MODE == 3'h4 |-> PANEL_DATA_BUS[23:4] == 20'h0) else $error("upper lanes used");
  chk_lanes_stn8: assert property (@(posedge PIX_CLK) disable iff (RST)
    MODE inside {3'h2, 3'h3} |-> PANEL_DATA_BUS[23:8] == 16'h0) else $error("lanes 23..8 used");
  chk_lanes_stn16: assert property (@(posedge PIX_CLK) disable iff (RST)
    MODE == 3'h1 |-> PANEL_DATA_BUS[23:16] == 8'h0) else $error("lanes 23..16 used");
  chk_frame_with_data: assert property (@(posedge PIX_CLK) disable iff (RST)
    $rose(PANEL_FRAME_SYNC) |-> PANEL_DATA_VALID) else $error("frame sync without data");
  chk_ready_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
    !BUSY |-> !PIX_READY) else $error("ready while idle");
endmodule : pdblm_mapper_sva

// >>> sim/pdblm_panel_model.sv
`timescale 1ns/1ns

module pdblm_panel_model (
  input wire logic pix_clk,
  input wire logic [23:0] bus,
  input wire logic valid,
  input wire logic line_sync,
  input wire logic frame_sync
);
  logic [23:0] words[$];
  int line_len[$];
  int frames = 0;
  int cnt = 0;
  logic sync_q = 1'b0;
  logic fs_q = 1'b0;

  task automatic clear();
    words.delete();
    line_len.delete();
    frames = 0;
    cnt = 0;
  endtask : clear

  // Panel latches a line on the rising edge of line sync
  always @(posedge pix_clk)
  begin
    if (valid)
    begin
      words.push_back(bus);
      cnt++;
    end
    if (line_sync && !sync_q)
    begin
      line_len.push_back(cnt);
      cnt = 0;
    end
    if (frame_sync && !fs_q)
      frames++;
    sync_q <= line_sync;
    fs_q <= frame_sync;
  end
endmodule : pdblm_panel_model

// >>> sim/pdblm_mapper_bench.sv
`timescale 1ns/1ns

module pdblm_mapper_bench;
  logic CLK_SYS = 1'b0;
  logic PIX_CLK = 1'b0;
  logic RST = 1'b1;
  logic ENABLE = 1'b0;
  logic [2:0] MODE = 3'h0;
  logic COLOUR = 1'b0;
  logic [10:0] LINE_PIXELS = 11'h0;
  logic [10:0] FRAME_LINES = 11'h0;
  logic [23:0] PIX_DATA = 24'h0;
  logic PIX_VALID = 1'b0;
  logic PIX_READY;
  logic BUSY;
  logic [23:0] PANEL_DATA_BUS;
  logic PANEL_DATA_VALID;
  logic PANEL_LINE_SYNC;
  logic PANEL_FRAME_SYNC;
  int n_errors = 0;
  int comparisons = 0;
  int stalls;
  logic [23:0] exp_q[$];

  always #5 CLK_SYS = ~CLK_SYS;

  // Odd start offset keeps the link clock unrelated in phase
  initial
  begin
    #3;
    forever
    begin
      #7 PIX_CLK = ~PIX_CLK;
      #8 PIX_CLK = ~PIX_CLK;
    end
  end

  // Six bit shades, so the MSB alignment is visible
  pdblm_mapper #(.COMP_BITS(6), .FIFO_DEPTH(8)) DUT (.CLK_SYS(CLK_SYS), .RST(RST),
    .PIX_CLK(PIX_CLK), .ENABLE(ENABLE), .MODE(MODE), .COLOUR(COLOUR),
    .LINE_PIXELS(LINE_PIXELS), .FRAME_LINES(FRAME_LINES), .PIX_DATA(PIX_DATA),
    .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .BUSY(BUSY),
    .PANEL_DATA_BUS(PANEL_DATA_BUS), .PANEL_DATA_VALID(PANEL_DATA_VALID),
    .PANEL_LINE_SYNC(PANEL_LINE_SYNC), .PANEL_FRAME_SYNC(PANEL_FRAME_SYNC));

  pdblm_panel_model u_panel (.pix_clk(PIX_CLK), .bus(PANEL_DATA_BUS),
    .valid(PANEL_DATA_VALID), .line_sync(PANEL_LINE_SYNC), .frame_sync(PANEL_FRAME_SYNC));

  // ********************************
  // Shared tasks
  // ********************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic run_frame(input logic [2:0] mode, input logic colour, input int pix,
    input int lines, input int shifts, input logic [23:0] mask);
    logic [23:0] d;
    logic r;
    int n;
    n = lines * shifts;
    u_panel.clear();
    exp_q.delete();
    stalls = 0;
    @(posedge CLK_SYS);
    MODE <= mode;
    COLOUR <= colour;
    LINE_PIXELS <= 11'(pix);
    FRAME_LINES <= 11'(lines);
    ENABLE <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      if (i == 1)
        stalls = 0;
      d = 24'h3c1a95 + 24'(i) * 24'h050b13;
      if (mode == 3'h0)
        d = d & 24'h3f3f3f;
      exp_q.push_back(mode == 3'h0 ? d << 2 : mode == 3'h2 ? {16'h0, d[11:8], d[3:0]} : d & mask);
      PIX_VALID <= 1'b1;
      PIX_DATA <= d;
      // Hold the word until ready is seen at a rising edge
      for (int w = 0; w < 300; w++)
      begin
        @(negedge CLK_SYS);
        r = PIX_READY;
        @(posedge CLK_SYS);
        if (r === 1'b1)
          break;
        stalls++;
      end
    end
    PIX_VALID <= 1'b0;
    ENABLE <= 1'b0;
    for (int w = 0; w < 400 && u_panel.line_len.size() < lines; w++)
      @(posedge PIX_CLK);
    repeat (10) @(posedge PIX_CLK);
    check(24'(u_panel.words.size()), 24'(n));
    foreach (exp_q[k]) check(u_panel.words[k], exp_q[k]);
    foreach (u_panel.line_len[k]) check(24'(u_panel.line_len[k]), 24'(shifts));
    check(24'(u_panel.line_len.size()), 24'(lines));
    check(24'(u_panel.frames), 24'h1);
    check(24'(BUSY), 24'h0);
    check(24'(PIX_READY), 24'h0);
  endtask : run_frame

  // ********************************
  // Scenarios
  // ********************************
  task automatic test_tft();
    run_frame(3'h0, 1'b0, 12, 2, 12, 24'hffffff);
    check(24'(stalls > 0), 24'h1);
    $display("test tft done");
  endtask : test_tft

  // Five pixels per line, so every lane count leaves a padded last shift
  task automatic test_stn();
    int lanes;
    logic [23:0] mask;
    for (int m = 1; m <= 4; m++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        lanes = (m == 1 || m == 3) ? 8 : 4;
        mask = m == 1 ? 24'h00ffff : m == 2 ? 24'h000f0f : m == 3 ? 24'h0000ff : 24'h00000f;
        run_frame(3'(m), 1'(c), 5, 2, (5 * (c ? 3 : 1) + lanes - 1) / lanes, mask);
      end
    end
    $display("test stn done");
  endtask : test_stn

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (10) @(posedge CLK_SYS);
    test_tft();
    test_stn();
    close_out();
  end

  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule : pdblm_mapper_bench

bind pdblm_mapper pdblm_mapper_sva u_sva (.CLK_SYS(CLK_SYS), .RST(RST), .PIX_CLK(PIX_CLK),
  .MODE(MODE), .BUSY(BUSY), .PIX_READY(PIX_READY), .PANEL_DATA_BUS(PANEL_DATA_BUS),
  .PANEL_DATA_VALID(PANEL_DATA_VALID), .PANEL_LINE_SYNC(PANEL_LINE_SYNC),
  .PANEL_FRAME_SYNC(PANEL_FRAME_SYNC));
